// ==== hw/mieu_core.sv ====
/*
  Instruction execute unit of an 8-bit core: sequencer, accumulator,
  flags, stack, table reads and register port.
  Assumes an asynchronous program memory returning pm_data for pm_addr in
  the same cycle, and same-clock irq, wake and watchdog signals.
*/
`timescale 1ns/1ps
`include "mieu_defines.svh"
module mieu_core
(
  input  wire logic                  mclk,
  input  wire logic                  rst,
  output logic      [`MIEU_PCW-1:0]  pm_addr,
  input  wire logic [`MIEU_IW-1:0]   pm_data,
  input  wire logic [3:0]            reg_addr,
  input  wire logic [15:0]           reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic      [15:0]           reg_rdata,
  input  wire logic                  irq_req,
  input  wire logic                  wake_req,
  input  wire logic                  wdt_expire,
  output logic                       wdt_clear,
  output logic                       clk_stop,
  output logic                       instr_done,
  output logic                       cyc_pulse
);

  mieu_pkg::mieu_state_e state_r;
  mieu_pkg::mieu_op_e    op;
  logic [`MIEU_IW-1:0]   ir_r;
  logic [`MIEU_PCW-1:0]  pc_r;
  logic [`MIEU_PCW-1:0]  pc_nxt;
  logic [`MIEU_PCW-1:0]  taddr;
  logic [`MIEU_PCW-1:0]  stk_r [0:`MIEU_STK_DEPTH-1];
  logic [1:0]            sp_r;
  logic [7:0]            acc_r;
  logic [7:0]            acc_nxt;
  logic                  c_r, ac_r, z_r, ov_r;
  logic                  c_nxt, ac_nxt, z_nxt, ov_nxt;
  logic                  wdx_flag_r;
  logic                  slp_flag_r;
  logic                  gie_r;
  logic                  run_r;
  logic [1:0]            pre_r;
  logic [1:0]            pre_nxt;
  logic [7:0]            tblp_r;
  logic [2:0]            tbpage_r;
  logic [7:0]            tbl_upper_r;
  logic [7:0]            opnd, imm, addin, res, mem_wd;
  logic [8:0]            sum;
  logic [4:0]            lo;
  logic [2:0]            bsel;
  logic                  cin, c7, mem_we, two, skip, skip_op;
  logic                  push, pop, wclr, halt, gie_set, pcl_hit;
  logic                  ex, irq_take;
  logic [7:0]            dm_rdata, dm_raddr, dm_wdata;
  logic                  dm_we;
  logic [7:0]            status_w;

  function automatic logic is_tab(input mieu_pkg::mieu_op_e o);
    is_tab = (o == mieu_pkg::op_table_read_page) ||
             (o == mieu_pkg::op_table_read_current) ||
             (o == mieu_pkg::op_table_read_last);
  endfunction

  function automatic logic is_imm(input mieu_pkg::mieu_op_e o);
    is_imm = (o == mieu_pkg::op_add_a_x) || (o == mieu_pkg::op_and_a_x);
  endfunction

  assign op       = mieu_pkg::mieu_op_e'(ir_r[16:11]);
  assign ex       = (state_r == mieu_pkg::st_exec);
  assign irq_take = (state_r == mieu_pkg::st_fetch) && run_r && gie_r && irq_req;

  always_comb
  begin
    case (op)
      mieu_pkg::op_table_read_page:    taddr = {tbpage_r, tblp_r};
      mieu_pkg::op_table_read_current: taddr = {pc_r[10:8], tblp_r};
      default:                         taddr = {`MIEU_LAST_PG, tblp_r};
    endcase
  end

  // Execute stage: results of the instruction held in ir_r
  always_comb
  begin
    opnd    = (ir_r[7:0] == `MIEU_PCL_ADDR) ? pc_r[7:0] : dm_rdata;
    imm     = ir_r[7:0];
    bsel    = ir_r[10:8];
    addin   = is_imm(op) ? imm : opnd;
    cin     = (op == mieu_pkg::op_adc_a_m) || (op == mieu_pkg::op_add_carry_to_mem);
    cin     = cin & c_r;
    sum     = {1'b0, acc_r} + {1'b0, addin} + {8'h00, cin};
    lo      = {1'b0, acc_r[3:0]} + {1'b0, addin[3:0]} + {4'h0, cin};
    c7      = acc_r[7] ^ addin[7] ^ sum[7];
    res     = sum[7:0];
    acc_nxt = acc_r;
    c_nxt   = c_r;
    ac_nxt  = ac_r;
    z_nxt   = z_r;
    ov_nxt  = ov_r;
    mem_we  = 1'b0;
    mem_wd  = opnd;
    pc_nxt  = pc_r + 11'h001;
    two     = 1'b0;
    skip    = 1'b0;
    skip_op = 1'b0;
    push    = 1'b0;
    pop     = 1'b0;
    wclr    = 1'b0;
    halt    = 1'b0;
    gie_set = 1'b0;
    pre_nxt = 2'b00;
    case (op)
      mieu_pkg::op_mov_a_m: acc_nxt = opnd;
      mieu_pkg::op_mov_a_x: acc_nxt = imm;
      mieu_pkg::op_mov_m_a:
      begin
        mem_we = 1'b1;
        mem_wd = acc_r;
      end
      mieu_pkg::op_clr_bit, mieu_pkg::op_set_bit:
      begin
        mem_we       = 1'b1;
        mem_wd[bsel] = (op == mieu_pkg::op_set_bit);
      end
      mieu_pkg::op_jump:
      begin
        pc_nxt = ir_r[10:0];
        two    = 1'b1;
      end
      mieu_pkg::op_call:
      begin
        push   = 1'b1;
        pc_nxt = ir_r[10:0];
        two    = 1'b1;
      end
      mieu_pkg::op_ret, mieu_pkg::op_ret_load, mieu_pkg::op_reti:
      begin
        pop    = 1'b1;
        pc_nxt = stk_r[sp_r - 2'h1];
        two    = 1'b1;
        if (op == mieu_pkg::op_ret_load)
          acc_nxt = imm;
        gie_set = (op == mieu_pkg::op_reti);
      end
      mieu_pkg::op_skip_if_zero:
      begin
        skip_op = 1'b1;
        skip    = (opnd == 8'h00);
      end
      mieu_pkg::op_skip_zero_mov:
      begin
        skip_op = 1'b1;
        skip    = (opnd == 8'h00);
        acc_nxt = opnd;
      end
      mieu_pkg::op_skip_bit_zero, mieu_pkg::op_skip_if_nonzero:
      begin
        skip_op = 1'b1;
        skip    = opnd[bsel] ^ (op == mieu_pkg::op_skip_bit_zero);
      end
      mieu_pkg::op_inc_skip_if_zero, mieu_pkg::op_dec_skip_if_zero,
      mieu_pkg::op_inc_skip_zero_a, mieu_pkg::op_dec_skip_zero_a:
      begin
        skip_op = 1'b1;
        if ((op == mieu_pkg::op_inc_skip_if_zero) || (op == mieu_pkg::op_inc_skip_zero_a))
          res = opnd + 8'h01;
        else
          res = opnd - 8'h01;
        skip = (res == 8'h00);
        if ((op == mieu_pkg::op_inc_skip_if_zero) || (op == mieu_pkg::op_dec_skip_if_zero))
        begin
          mem_we = 1'b1;
          mem_wd = res;
        end
        else
          acc_nxt = res;
      end
      mieu_pkg::op_table_read_page, mieu_pkg::op_table_read_current,
      mieu_pkg::op_table_read_last:
        two = 1'b1;
      mieu_pkg::op_clr_mem, mieu_pkg::op_set_mem:
      begin
        mem_we = 1'b1;
        mem_wd = (op == mieu_pkg::op_set_mem) ? 8'hff : 8'h00;
      end
      mieu_pkg::op_wdt_clear: wclr = 1'b1;
      mieu_pkg::op_watchdog_preclear_a:
      begin
        wclr    = (pre_r == 2'b10);
        pre_nxt = wclr ? 2'b00 : 2'b01;
      end
      mieu_pkg::op_watchdog_preclear_b:
      begin
        wclr    = (pre_r == 2'b01);
        pre_nxt = wclr ? 2'b00 : 2'b10;
      end
      mieu_pkg::op_swap:
      begin
        mem_we = 1'b1;
        mem_wd = {opnd[3:0], opnd[7:4]};
      end
      mieu_pkg::op_swap_a: acc_nxt = {opnd[3:0], opnd[7:4]};
      mieu_pkg::op_halt: halt = 1'b1;
      mieu_pkg::op_add_a_m, mieu_pkg::op_add_a_x, mieu_pkg::op_adc_a_m,
      mieu_pkg::op_add_to_mem, mieu_pkg::op_add_carry_to_mem:
      begin
        c_nxt  = sum[8];
        ac_nxt = lo[4];
        z_nxt  = (res == 8'h00);
        ov_nxt = c7 ^ sum[8];
        if ((op == mieu_pkg::op_add_to_mem) || (op == mieu_pkg::op_add_carry_to_mem))
        begin
          mem_we = 1'b1;
          mem_wd = res;
        end
        else
          acc_nxt = res;
      end
      mieu_pkg::op_and_a_m, mieu_pkg::op_and_a_x, mieu_pkg::op_and_to_mem:
      begin
        res   = acc_r & addin;
        z_nxt = (res == 8'h00);
        if (op == mieu_pkg::op_and_to_mem)
        begin
          mem_we = 1'b1;
          mem_wd = res;
        end
        else
          acc_nxt = res;
      end
      default: acc_nxt = acc_r;
    endcase
    if (skip)
    begin
      pc_nxt = pc_r + 11'h002;
      two    = 1'b1;
    end
    pcl_hit = mem_we && (ir_r[7:0] == `MIEU_PCL_ADDR);
    if (pcl_hit)
    begin
      mem_we = 1'b0;
      pc_nxt = {pc_r[10:8], mem_wd};
      two    = 1'b1;
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      state_r <= mieu_pkg::st_fetch;
    else
      case (state_r)
        mieu_pkg::st_fetch:
          if (irq_take)
            state_r <= mieu_pkg::st_dummy_f;
          else if (run_r)
            state_r <= mieu_pkg::st_exec;
        mieu_pkg::st_exec:
          if (halt)
            state_r <= mieu_pkg::st_halt;
          else if (two)
            state_r <= mieu_pkg::st_dummy_f;
          else
            state_r <= mieu_pkg::st_fetch;
        mieu_pkg::st_dummy_f: state_r <= mieu_pkg::st_dummy_e;
        mieu_pkg::st_halt:
          if (wake_req)
            state_r <= mieu_pkg::st_fetch;
        default: state_r <= mieu_pkg::st_fetch;
      endcase
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      ir_r    <= '0;
      pc_r    <= `MIEU_RST_PC;
      pm_addr <= `MIEU_RST_PC;
    end
    else
    begin
      if ((state_r == mieu_pkg::st_fetch) && !irq_take)
        ir_r <= pm_data;
      if (irq_take)
        pc_r <= `MIEU_IRQ_VEC;
      else if (ex)
        pc_r <= pc_nxt;
      if (irq_take)
        pm_addr <= `MIEU_IRQ_VEC;
      else if (ex)
        pm_addr <= is_tab(op) ? taddr : pc_nxt;
      else
        pm_addr <= pc_r;
    end
  end

  // Stack of return addresses
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      sp_r <= 2'h0;
      for (int i = 0; i < `MIEU_STK_DEPTH; i++)
        stk_r[i] <= '0;
    end
    else if (irq_take || (ex && push))
    begin
      stk_r[sp_r] <= irq_take ? pc_r : pc_r + 11'h001;
      sp_r        <= sp_r + 2'h1;
    end
    else if (ex && pop)
      sp_r <= sp_r - 2'h1;
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      acc_r <= 8'h00;
      c_r   <= 1'b0;
      ac_r  <= 1'b0;
      z_r   <= 1'b0;
      ov_r  <= 1'b0;
      pre_r <= 2'b00;
    end
    else if (ex)
    begin
      acc_r <= acc_nxt;
      c_r   <= c_nxt;
      ac_r  <= ac_nxt;
      z_r   <= z_nxt;
      ov_r  <= ov_nxt;
      pre_r <= pre_nxt;
    end
  end

  // Expiry from the watchdog wins over any clear in the same cycle
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      wdx_flag_r <= 1'b0;
      slp_flag_r <= 1'b0;
      wdt_clear  <= 1'b0;
    end
    else
    begin
      wdt_clear <= ex && (wclr || halt);
      if (ex && (wclr || halt))
        slp_flag_r <= halt;
      if (wdt_expire)
        wdx_flag_r <= 1'b1;
      else if (ex && (wclr || halt))
        wdx_flag_r <= 1'b0;
    end
  end

  // Interrupt enable: hardware set wins over a register write
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      gie_r    <= 1'b0;
      run_r    <= 1'b0;
      tblp_r   <= 8'h00;
      tbpage_r <= 3'h0;
    end
    else
    begin
      if (reg_wr && (reg_addr == `MIEU_REG_CTRL))
        run_r <= reg_wdata[`MIEU_CTRL_RUN];
      if (reg_wr && (reg_addr == `MIEU_REG_TBLP))
        tblp_r <= reg_wdata[7:0];
      if (reg_wr && (reg_addr == `MIEU_REG_TBPAGE))
        tbpage_r <= reg_wdata[2:0];
      if (ex && gie_set)
        gie_r <= 1'b1;
      else if (irq_take)
        gie_r <= 1'b0;
      else if (reg_wr && (reg_addr == `MIEU_REG_CTRL))
        gie_r <= reg_wdata[`MIEU_CTRL_GIE];
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      tbl_upper_r <= 8'h00;
    else if ((state_r == mieu_pkg::st_dummy_f) && is_tab(op))
      tbl_upper_r <= pm_data[15:8];
  end

  assign dm_raddr = (state_r == mieu_pkg::st_fetch) ? pm_data[7:0] : ir_r[7:0];
  assign dm_we    = (ex && mem_we) || ((state_r == mieu_pkg::st_dummy_f) && is_tab(op));
  assign dm_wdata = ex ? mem_wd : pm_data[7:0];

  mieu_dmem u_dmem
  (
    .mclk  (mclk),
    .rst   (rst),
    .raddr (dm_raddr),
    .rdata (dm_rdata),
    .we    (dm_we),
    .waddr (ir_r[7:0]),
    .wdata (dm_wdata)
  );

  always_comb
  begin
    status_w               = 8'h00;
    status_w[`MIEU_ST_C]   = c_r;
    status_w[`MIEU_ST_AC]  = ac_r;
    status_w[`MIEU_ST_Z]   = z_r;
    status_w[`MIEU_ST_OV]  = ov_r;
    status_w[`MIEU_ST_SLP] = slp_flag_r;
    status_w[`MIEU_ST_WDX] = wdx_flag_r;
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      reg_rdata <= 16'h0000;
    else if (!reg_rd)
      reg_rdata <= 16'h0000;
    else
      case (reg_addr)
        `MIEU_REG_ACC:    reg_rdata <= {8'h00, acc_r};
        `MIEU_REG_STATUS: reg_rdata <= {8'h00, status_w};
        `MIEU_REG_PC:     reg_rdata <= {5'h00, pc_r};
        `MIEU_REG_TBLP:   reg_rdata <= {8'h00, tblp_r};
        `MIEU_REG_TBPAGE: reg_rdata <= {13'h0000, tbpage_r};
        `MIEU_REG_TABLE_UPPER_LATCH:   reg_rdata <= {8'h00, tbl_upper_r};
        `MIEU_REG_CTRL:   reg_rdata <= {14'h0000, gie_r, run_r};
        `MIEU_REG_SP:     reg_rdata <= {14'h0000, sp_r};
        default:          reg_rdata <= 16'h0000;
      endcase
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      instr_done <= 1'b0;
      cyc_pulse  <= 1'b0;
      clk_stop   <= 1'b0;
    end
    else
    begin
      instr_done <= (ex && (!two || halt)) || (state_r == mieu_pkg::st_dummy_e);
      cyc_pulse  <= ex || (state_r == mieu_pkg::st_dummy_e);
      clk_stop   <= (ex && halt) || ((state_r == mieu_pkg::st_halt) && !wake_req);
    end
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (rst);

  skip_two_a: assert property (ex && skip |=> state_r == mieu_pkg::st_dummy_f
    ##1 state_r == mieu_pkg::st_dummy_e) else $error("taken skip not two cycles");
  noskip_one_a: assert property (ex && skip_op && !skip && !pcl_hit
    |=> state_r == mieu_pkg::st_fetch) else $error("untaken skip not one cycle");
  pcl_two_a: assert property (ex && pcl_hit |=> state_r == mieu_pkg::st_dummy_f
    && pc_r[7:0] == $past(mem_wd)) else $error("counter low write wrong");
  wdt_pair_a: assert property (ex && op == mieu_pkg::op_watchdog_preclear_b
    && pre_r == 2'b01 && !wdt_expire |=> !wdx_flag_r && !slp_flag_r && wdt_clear)
    else $error("preclear pair did not clear");
  wdt_lone_a: assert property (ex && op == mieu_pkg::op_watchdog_preclear_a
    && pre_r != 2'b10 |=> $stable(slp_flag_r) && !wdt_clear)
    else $error("lone preclear had effect");
  wdt_clr_a: assert property (ex && op == mieu_pkg::op_wdt_clear && !wdt_expire
    |=> wdt_clear && !wdx_flag_r && !slp_flag_r) else $error("watchdog clear failed");
  call_push_a: assert property (ex && op == mieu_pkg::op_call
    |=> pc_r == $past(ir_r[10:0]) && stk_r[sp_r - 2'h1] == $past(pc_r) + 11'h001
    ##1 state_r == mieu_pkg::st_dummy_e) else $error("call push or target wrong");
  adc_sum_a: assert property (ex && op == mieu_pkg::op_adc_a_m
    |=> acc_r == $past(acc_r) + $past(opnd) + $past(c_r)) else $error("adc sum wrong");
  add_carry_a: assert property (ex && op == mieu_pkg::op_add_a_x
    |=> c_r == ({1'b0, $past(acc_r)} + {1'b0, $past(imm)} > 9'h0ff))
    else $error("add carry wrong");
  and_flag_a: assert property (ex && op == mieu_pkg::op_and_a_m
    |=> $stable(c_r) && $stable(ov_r) && z_r == (($past(acc_r) & $past(opnd)) == 8'h00))
    else $error("and flags wrong");
  clr_mem_a: assert property (ex && op == mieu_pkg::op_clr_mem && !pcl_hit
    |-> dm_we && dm_wdata == 8'h00 ##1 $stable(c_r) && $stable(z_r))
    else $error("clear memory wrong");
  halt_a: assert property (ex && halt && !wdt_expire && !wake_req
    |=> state_r == mieu_pkg::st_halt && slp_flag_r && !wdx_flag_r && clk_stop)
    else $error("halt entry wrong");
  reti_a: assert property (ex && op == mieu_pkg::op_reti
    |=> gie_r && pc_r == $past(stk_r[sp_r - 2'h1])) else $error("return from irq wrong");
  nop_a: assert property (ex && op == mieu_pkg::op_nop
    |=> $stable(acc_r) && pc_r == $past(pc_r) + 11'h001 && state_r == mieu_pkg::st_fetch)
    else $error("nop changed state");

endmodule

// ==== hw/mieu_defines.svh ====
/*
  Constants of the instruction execute unit: register offsets, status
  bit positions, reset values and fixed addresses.
  Assumes inclusion by bare name from the unit's design files.
*/
`ifndef MIEU_DEFINES_SVH
`define MIEU_DEFINES_SVH

`define MIEU_IW        17
`define MIEU_PCW       11
`define MIEU_STK_DEPTH 4

`define MIEU_REG_ACC    4'h0
`define MIEU_REG_STATUS 4'h1
`define MIEU_REG_PC     4'h2
`define MIEU_REG_TBLP   4'h3
`define MIEU_REG_TBPAGE 4'h4
`define MIEU_REG_TABLE_UPPER_LATCH   4'h5
`define MIEU_REG_CTRL   4'h6
`define MIEU_REG_SP     4'h7

`define MIEU_ST_C   0
`define MIEU_ST_AC  1
`define MIEU_ST_Z   2
`define MIEU_ST_OV  3
`define MIEU_ST_SLP 4
`define MIEU_ST_WDX 5

`define MIEU_CTRL_RUN 0
`define MIEU_CTRL_GIE 1

`define MIEU_PCL_ADDR 8'h06
`define MIEU_IRQ_VEC  11'h004
`define MIEU_RST_PC   11'h000
`define MIEU_LAST_PG  3'h7

`endif

// ==== hw/mieu_dmem.sv ====
/*
  Data memory of the execute unit: 256 bytes, one write port and one
  registered read port.
  Assumes write and read addresses stable around the rising edge.
*/
`timescale 1ns/1ps
module mieu_dmem
(
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic [7:0] raddr,
  output logic      [7:0] rdata,
  input  wire logic       we,
  input  wire logic [7:0] waddr,
  input  wire logic [7:0] wdata
);

  logic [7:0] mem_r [0:255];

  always_ff @(posedge mclk)
  begin
    if (we)
      mem_r[waddr] <= wdata;
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      rdata <= 8'h00;
    else
      rdata <= mem_r[raddr];
  end

endmodule

// ==== hw/mieu_pkg.sv ====
/*
  Types of the instruction execute unit: opcodes and sequencer states.
  Assumes nothing of its surroundings.
*/
package mieu_pkg;

  typedef enum logic [5:0] {
    op_nop, op_mov_a_m, op_mov_m_a, op_mov_a_x, op_clr_bit, op_set_bit,
    op_jump, op_skip_if_zero, op_skip_zero_mov, op_skip_bit_zero,
    op_skip_if_nonzero, op_inc_skip_if_zero, op_dec_skip_if_zero,
    op_inc_skip_zero_a, op_dec_skip_zero_a, op_call, op_ret, op_ret_load,
    op_reti, op_table_read_page, op_table_read_current, op_table_read_last,
    op_clr_mem, op_set_mem, op_wdt_clear, op_watchdog_preclear_a,
    op_watchdog_preclear_b, op_swap, op_swap_a, op_halt, op_add_a_m,
    op_add_to_mem, op_add_a_x, op_adc_a_m, op_add_carry_to_mem,
    op_and_a_m, op_and_to_mem, op_and_a_x
  } mieu_op_e;

  typedef enum logic [2:0] {
    st_fetch, st_exec, st_dummy_f, st_dummy_e, st_halt
  } mieu_state_e;

endpackage

// ==== verif/mcu_instruction_execute_unit_tb_top.sv ====
/*
  Self-checking bench of the execute unit: one small program a scenario, except the register scenario, which runs none.
  Assumes the core, its data memory and the program memory model.
*/
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_fail++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module mcu_instruction_execute_unit_tb_top;
  logic        mclk;
  logic        rst = 1'b1;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        wake_req = 1'b0;
  logic        irq_req = 1'b0;
  logic        wdt_expire = 1'b0;
  logic [3:0]  reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic [15:0] reg_rdata;
  logic [15:0] rd_v;
  logic [10:0] pm_addr;
  logic [16:0] pm_data;
  logic        wdt_clear;
  logic        clk_stop;
  logic        instr_done;
  int          n_fail = 0;
  int          n_compared = 0;
  int          cnt = 0;
  int          n_wdt = 0;
  int          ticks = 0;
  int          dq [$];
  logic [16:0] pq [$];

  mieu_core dut (.mclk(mclk), .rst(rst), .pm_addr(pm_addr), .pm_data(pm_data),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq_req(irq_req), .wake_req(wake_req),
    .wdt_expire(wdt_expire), .wdt_clear(wdt_clear), .clk_stop(clk_stop),
    .instr_done(instr_done), .cyc_pulse());
  mieu_prog_rom rom (.pm_addr(pm_addr), .pm_data(pm_data));

  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // Clocks per instruction, watchdog clears, hang guard
  always @(posedge mclk)
  begin
    cnt <= cnt + 1;
    ticks <= ticks + 1;
    if (instr_done === 1'b1)
    begin
      dq.push_back(cnt);
      cnt <= 1;
    end
    if (wdt_clear === 1'b1)
      n_wdt <= n_wdt + 1;
    if (ticks == 20000)
    begin
      n_fail++;
      report_and_stop();
    end
  end

  function automatic logic [16:0] w(mieu_pkg::mieu_op_e op, logic [10:0] f);
    return {op, f};
  endfunction

  task automatic report_and_stop();
    if (n_fail == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic do_reset();
    rst <= 1'b1;
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic wr(logic [3:0] a, logic [15:0] d);
    @(posedge mclk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(logic [3:0] a);
    @(posedge mclk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 rd_v = reg_rdata;
  endtask

  // Loads the program, sets run, waits for n completions
  task automatic start(int n);
    int k;
    foreach (pq[i]) rom.mem[i] = pq[i];
    n_wdt = 0;
    wr(4'h6, 16'h0001);
    dq.delete();
    k = 0;
    while (dq.size() < n && k < 300)
    begin
      @(posedge mclk);
      k++;
    end
    repeat (8) @(posedge mclk);
  endtask

  task automatic s_regs();
    do_reset();
    wr(4'h0, 16'h00aa);
    rd(4'h0);
    `CHK(rd_v, 16'h0000)
    rd(4'hf);
    `CHK(rd_v, 16'h0000)
  endtask

  task automatic s_alu();
    do_reset();
    pq = '{w(mieu_pkg::op_mov_a_x, 11'h07f), w(mieu_pkg::op_add_a_x, 11'h001),
      w(mieu_pkg::op_mov_m_a, 11'h020), w(mieu_pkg::op_and_a_x, 11'h00f),
      w(mieu_pkg::op_mov_a_m, 11'h020), w(mieu_pkg::op_adc_a_m, 11'h020),
      w(mieu_pkg::op_add_carry_to_mem, 11'h020), w(mieu_pkg::op_mov_a_m, 11'h020),
      w(mieu_pkg::op_add_a_m, 11'h020), w(mieu_pkg::op_jump, 11'h009)};
    start(10);
    rd(4'h0);
    `CHK(rd_v, 16'h0002)
    rd(4'h1);
    `CHK(rd_v, 16'h0009)
    for (int i = 1; i < 9; i++)
      `CHK(dq[i], 2)
  endtask

  task automatic s_branch();
    int e [8] = '{4, 2, 2, 4, 4, 2, 2, 4};
    do_reset();
    pq = '{w(mieu_pkg::op_clr_mem, 11'h030), w(mieu_pkg::op_skip_if_zero, 11'h030),
      w(mieu_pkg::op_mov_a_x, 11'h055), w(mieu_pkg::op_inc_skip_if_zero, 11'h030),
      w(mieu_pkg::op_skip_zero_mov, 11'h030), w(mieu_pkg::op_call, 11'h009),
      w(mieu_pkg::op_set_bit, 11'h730), w(mieu_pkg::op_mov_a_m, 11'h030),
      w(mieu_pkg::op_jump, 11'h008), w(mieu_pkg::op_ret_load, 11'h042)};
    start(9);
    rd(4'h0);
    `CHK(rd_v, 16'h0081)
    rd(4'h1);
    `CHK(rd_v, 16'h0000)
    for (int i = 0; i < 8; i++)
      `CHK(dq[i+1], e[i])
  endtask

  task automatic s_pcl();
    do_reset();
    pq = '{w(mieu_pkg::op_mov_a_x, 11'h004), w(mieu_pkg::op_mov_m_a, 11'h006),
      w(mieu_pkg::op_mov_a_x, 11'h011), w(mieu_pkg::op_mov_a_x, 11'h012),
      w(mieu_pkg::op_mov_m_a, 11'h050), w(mieu_pkg::op_swap_a, 11'h050),
      w(mieu_pkg::op_jump, 11'h006)};
    start(4);
    rd(4'h0);
    `CHK(rd_v, 16'h0040)
    `CHK(dq[1], 4)
  endtask

  task automatic s_table();
    do_reset();
    rom.mem[11'h210] = 17'h0a5c3;
    rom.mem[11'h710] = 17'h101e7;
    rom.mem[11'h010] = 17'h07755;
    wr(4'h3, 16'h0010);
    wr(4'h4, 16'h0002);
    pq = '{w(mieu_pkg::op_nop, 11'h000), w(mieu_pkg::op_table_read_page, 11'h040),
      w(mieu_pkg::op_table_read_last, 11'h041), w(mieu_pkg::op_table_read_current, 11'h042),
      w(mieu_pkg::op_mov_a_m, 11'h041), w(mieu_pkg::op_add_a_m, 11'h042),
      w(mieu_pkg::op_jump, 11'h006)};
    start(6);
    rd(4'h0);
    `CHK(rd_v, 16'h003c)
    rd(4'h5);
    `CHK(rd_v, 16'h0077)
    for (int i = 1; i < 4; i++)
      `CHK(dq[i], 4)
  endtask

  // Interrupt entry, handler and return re-enabling interrupts
  task automatic s_irq();
    do_reset();
    pq = '{w(mieu_pkg::op_jump, 11'h000), w(mieu_pkg::op_nop, 11'h000),
      w(mieu_pkg::op_nop, 11'h000), w(mieu_pkg::op_nop, 11'h000),
      w(mieu_pkg::op_mov_a_x, 11'h05a), w(mieu_pkg::op_reti, 11'h000)};
    foreach (pq[i]) rom.mem[i] = pq[i];
    irq_req <= 1'b1;
    wr(4'h6, 16'h0003);
    repeat (6) @(posedge mclk);
    irq_req <= 1'b0;
    repeat (30) @(posedge mclk);
    rd(4'h6);
    `CHK(rd_v, 16'h0003)
    rd(4'h7);
    `CHK(rd_v, 16'h0000)
    rd(4'h0);
    `CHK(rd_v, 16'h005a)
  endtask

  task automatic s_wdt(mieu_pkg::mieu_op_e a, mieu_pkg::mieu_op_e b, logic [15:0] st,
                       int nw, logic stp);
    do_reset();
    wdt_expire <= 1'b1;
    @(posedge mclk);
    wdt_expire <= 1'b0;
    pq = '{w(a, 11'h000), w(b, 11'h000), w(mieu_pkg::op_jump, 11'h002)};
    start(1);
    rd(4'h1);
    `CHK(rd_v, st)
    `CHK(n_wdt, nw)
    `CHK(clk_stop, stp)
  endtask

  initial
  begin
    do_reset();
    s_regs();
    s_alu();
    s_branch();
    s_pcl();
    s_table();
    s_irq();
    s_wdt(mieu_pkg::op_watchdog_preclear_a, mieu_pkg::op_watchdog_preclear_a,
          16'h0020, 0, 1'b0);
    s_wdt(mieu_pkg::op_watchdog_preclear_a, mieu_pkg::op_watchdog_preclear_b,
          16'h0000, 1, 1'b0);
    s_wdt(mieu_pkg::op_wdt_clear, mieu_pkg::op_nop, 16'h0000, 1, 1'b0);
    s_wdt(mieu_pkg::op_halt, mieu_pkg::op_nop, 16'h0010, 1, 1'b1);
    wake_req <= 1'b1;
    repeat (4) @(posedge mclk);
    wake_req <= 1'b0;
    `CHK(clk_stop, 1'b0)
    report_and_stop();
  end
endmodule

// ==== verif/mieu_prog_rom.sv ====
/*
  Program memory model: 2048 words of 17 bits, read without a clock.
  Assumes the bench writes the words directly before each run.
*/
`timescale 1ns/1ps
module mieu_prog_rom
(
  input  wire logic [10:0] pm_addr,
  output logic      [16:0] pm_data
);
  logic [16:0] mem [0:2047];

  // Data follows the address in the same cycle
  assign pm_data = mem[pm_addr];

  initial
  begin
    foreach (mem[i]) mem[i] = 17'h00000;
  end
endmodule
